// *** common/pmewk_pkg.sv ***
package pmewk_pkg;

   typedef enum logic [1:0] {
      PMEWK_ST_HOLD = 2'b00,
      PMEWK_ST_LOAD = 2'b01,
      PMEWK_ST_NORMAL = 2'b10,
      PMEWK_ST_WAKE = 2'b11
   } pmewk_state_e;

   // wake flags byte, bit 0 is enable
   typedef struct packed {
      logic selfPowered;
      logic detect10High;
      logic wolLinkSel;
      logic pushPull;
      logic activeHigh;
      logic longPulse;
      logic pulseMode;
      logic enable;
   } pmewk_flags_s;

   // image delivered by the eeprom loader
   typedef struct packed {
      logic present;
      pmewk_flags_s flags;
      logic [10:0] wakeEn;
   } pmewk_ee_s;

endpackage : pmewk_pkg

// *** common/pmewk_regs.svh ***
`ifndef PMEWK_REGS_SVH
`define PMEWK_REGS_SVH

// register offsets on the plain register port
`define PMEWK_REG_PIN_DIR 8'h00
`define PMEWK_REG_PIN_OUT 8'h04
`define PMEWK_REG_WAKE_EN 8'h08
`define PMEWK_REG_INTERRUPT_STATUS_REG 8'h0c
`define PMEWK_REG_PIN_IN 8'h10
`define PMEWK_REG_CFG_STS 8'h14

// register reset values, all pins inputs
`define PMEWK_DIR_RST 11'h000
`define PMEWK_OUT_RST 11'h000
`define PMEWK_STS_RST 11'h000

// reserved wake pins per phy mode, one-hot over the 11 pins
`define PMEWK_INT_WAKE_OUT 11'h001
`define PMEWK_INT_MODE_SEL 11'h002
`define PMEWK_EXT_WAKE_OUT 11'h100
`define PMEWK_EXT_MODE_SEL 11'h200

// wake-capable pins per phy mode, and the pin with selectable level
`define PMEWK_CAND_INT 11'h7fc
`define PMEWK_CAND_EXT 11'h400
`define PMEWK_DET_SEL_PIN 11'h400

// strap position of the phy source select, 1 = external phy
`define PMEWK_STRAP_PHY 1'h0

// wake pulse lengths in clock cycles
`define PMEWK_PULSE_SHORT_CYC 16'h000f
`define PMEWK_PULSE_LONG_CYC 16'h0fa0

`endif

// *** hdl/pmewk_core.sv ***
`include "pmewk_regs.svh"

// Functional notes
// - straps undriven while any reset holds
// - straps captured at reset release
// - wake signalling only when self powered
// - mode select sampled during chip reset
// - wake pins chosen by phy mode
// - wake pin needs input and enable
// - pins reset to input, enables from eeprom
// - reserved pins keep wake role
// - wake inputs: pin 10 or 2-10
// - pin 10 level selectable, others low
// - magic packet raises wake
// - link partner raises wake
// - wake mode needs eeprom enable flag
// - wake events invisible to status registers
// - software cannot touch wake state
// - every reset in wake mode reloads eeprom
// - enter wake mode on select, enable and self power
// - wake flags decoded as documented
module pmewk_core #(
   parameter int unsigned STRAP_W = 2,
   parameter logic [15:0] PULSE_SHORT_CYC = `PMEWK_PULSE_SHORT_CYC,
   parameter logic [15:0] PULSE_LONG_CYC = `PMEWK_PULSE_LONG_CYC
) (
   // clock and power-on reset
   input wire logic clk,
   input wire logic resetn,
   // external chip reset, also the wake clear
   input wire logic externalChipResetN,
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrEn,
   input wire logic regRdEn,
   output logic [31:0] regRdData,
   // general-purpose pins
   input wire logic [10:0] gpioIn,
   output logic [10:0] gpioOut,
   output logic [10:0] gpioOe,
   // configuration straps
   input wire logic [STRAP_W-1:0] strapIn,
   input wire logic [STRAP_W-1:0] strapFunc,
   output logic [STRAP_W-1:0] strapOut,
   output logic [STRAP_W-1:0] strapOe,
   // eeprom loader
   output logic eeLoadReq,
   input wire logic eeDone,
   input wire pmewk_pkg::pmewk_ee_s eeImage,
   // ethernet wake sources
   input wire logic magicPacketDet,
   input wire logic linkPartnerDet,
   // mode seen by the rest of the chip
   output logic wakeWaitMode
);

   pmewk_pkg::pmewk_state_e stateFf;
   pmewk_pkg::pmewk_state_e nxt_state;
   pmewk_pkg::pmewk_flags_s flagsFf;
   logic [10:0] dirFf;
   logic [10:0] outFf;
   logic [10:0] wakeEnFf;
   logic [10:0] statusFf;
   logic [10:0] pinInFf;
   logic [STRAP_W-1:0] strapLatFf;
   logic modeSelFf;
   logic wakePendFf;
   logic [15:0] pulseCntFf;
   logic [31:0] rdMux;

   // decode of state and pin roles
   wire chipRst = !externalChipResetN;
   wire inHold = (stateFf == pmewk_pkg::PMEWK_ST_HOLD);
   wire inLoad = (stateFf == pmewk_pkg::PMEWK_ST_LOAD);
   wire inNormal = (stateFf == pmewk_pkg::PMEWK_ST_NORMAL);
   wire inWake = (stateFf == pmewk_pkg::PMEWK_ST_WAKE);
   wire releaseNow = inHold && externalChipResetN;
   wire phyExt = strapLatFf[`PMEWK_STRAP_PHY];
   wire phyExtLive = strapIn[`PMEWK_STRAP_PHY];
   wire [10:0] resOut = phyExt ? `PMEWK_EXT_WAKE_OUT
                               : `PMEWK_INT_WAKE_OUT;
   wire [10:0] resSel = phyExt ? `PMEWK_EXT_MODE_SEL
                               : `PMEWK_INT_MODE_SEL;
   wire [10:0] selLive = phyExtLive ? `PMEWK_EXT_MODE_SEL
                                    : `PMEWK_INT_MODE_SEL;
   wire [10:0] resAll = resOut | resSel;
   wire modeSelLive = |(gpioIn & selLive);
   wire [10:0] candMask = phyExt ? `PMEWK_CAND_EXT
                                 : `PMEWK_CAND_INT;

   // pin levels, active low except pin 10 when selected high
   wire [10:0] detHigh = flagsFf.detect10High ? `PMEWK_DET_SEL_PIN
                                              : 11'h000;
   wire [10:0] pinActive = ~(gpioIn ^ detHigh);
   wire [10:0] pinArmed = ~dirFf & wakeEnFf & pinActive;
   wire pinWake = |(pinArmed & candMask & ~resAll);

   // wake sources in wake-wait mode
   wire magicWake = magicPacketDet && !flagsFf.wolLinkSel;
   wire wakeEvent = inWake && externalChipResetN &&
                    (pinWake || magicWake || linkPartnerDet);
   wire nxt_wakePend = chipRst ? 1'b0 : (wakePendFf || wakeEvent);
   wire wakeRise = nxt_wakePend && !wakePendFf;

   // output level from flags: pulse or level, polarity, buffer
   wire [15:0] pulseLen = flagsFf.longPulse ? PULSE_LONG_CYC
                                            : PULSE_SHORT_CYC;
   wire wakeLevel = flagsFf.pulseMode ? (pulseCntFf != 16'h0000)
                                      : wakePendFf;
   wire wakeDrive = flagsFf.activeHigh ? wakeLevel : !wakeLevel;
   wire wakeOe = flagsFf.pushPull || !wakeDrive;
   wire wakeRoles = wakeWaitMode && flagsFf.selfPowered;

   // pin drivers, reserved pins follow wake logic in wake mode
   wire [10:0] normOe = (inHold || chipRst) ? 11'h000 : dirFf;
   wire [10:0] nxt_gpioOut = wakeRoles ?
      ((outFf & ~resAll) | (resOut & {11{wakeDrive}})) : outFf;
   wire [10:0] nxt_gpioOe = wakeRoles ?
      ((normOe & ~resAll) | (resOut & {11{wakeOe}})) : normOe;

   // mode decision once the eeprom image arrives
   wire wakeEntry = eeImage.present && eeImage.flags.enable &&
                    eeImage.flags.selfPowered && modeSelFf;

   // software writes, locked outside normal mode
   wire wrOk = regWrEn && inNormal;
   wire wrDir = wrOk && (regAddr == `PMEWK_REG_PIN_DIR);
   wire wrOut = wrOk && (regAddr == `PMEWK_REG_PIN_OUT);
   wire wrWake = wrOk && (regAddr == `PMEWK_REG_WAKE_EN);
   wire wrSts = wrOk && (regAddr == `PMEWK_REG_INTERRUPT_STATUS_REG);
   wire [10:0] stsSet = inNormal ? (pinArmed & ~resAll)
                                 : 11'h000;
   wire [10:0] stsClr = wrSts ? regWrData[10:0] : 11'h000;
   wire [10:0] nxt_status = (statusFf & ~stsClr) | stsSet;

   always_comb begin
      if (regAddr == `PMEWK_REG_PIN_DIR) begin
         rdMux = {21'h000000, dirFf};
      end else if (regAddr == `PMEWK_REG_PIN_OUT) begin
         rdMux = {21'h000000, outFf};
      end else if (regAddr == `PMEWK_REG_WAKE_EN) begin
         rdMux = {21'h000000, wakeEnFf};
      end else if (regAddr == `PMEWK_REG_INTERRUPT_STATUS_REG) begin
         rdMux = {21'h000000, statusFf};
      end else if (regAddr == `PMEWK_REG_PIN_IN) begin
         rdMux = {21'h000000, pinInFf};
      end else if (regAddr == `PMEWK_REG_CFG_STS) begin
         rdMux = 32'h00000000;
         rdMux[STRAP_W-1:0] = strapLatFf;
         rdMux[31] = inNormal;
      end else begin
         rdMux = 32'h00000000;
      end
   end

   always_comb begin
      nxt_state = stateFf;
      case (stateFf)
         pmewk_pkg::PMEWK_ST_HOLD: begin
            if (externalChipResetN) begin
               nxt_state = pmewk_pkg::PMEWK_ST_LOAD;
            end
         end
         pmewk_pkg::PMEWK_ST_LOAD: begin
            if (eeDone) begin
               nxt_state = wakeEntry ? pmewk_pkg::PMEWK_ST_WAKE
                                     : pmewk_pkg::PMEWK_ST_NORMAL;
            end
         end
         default: begin
            nxt_state = stateFf;
         end
      endcase
      if (chipRst) begin
         nxt_state = pmewk_pkg::PMEWK_ST_HOLD;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         stateFf <= pmewk_pkg::PMEWK_ST_HOLD;
      end else begin
         stateFf <= nxt_state;
      end
   end

   // straps: undriven in reset, captured on release
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         strapOe <= '0;
         strapOut <= '0;
         strapLatFf <= '0;
      end else begin
         strapOe <= (chipRst || inHold) ? '0 : '1;
         strapOut <= strapFunc;
         if (releaseNow) begin
            strapLatFf <= strapIn;
         end
      end
   end

   // mode select follows the pin for as long as reset holds
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         modeSelFf <= 1'b0;
      end else if (inHold) begin
         modeSelFf <= modeSelLive;
      end
   end

   // eeprom reload request on every release
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         eeLoadReq <= 1'b0;
      end else begin
         eeLoadReq <= releaseNow;
      end
   end

   // flags and pin wake enables from the eeprom image
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         flagsFf <= '0;
         wakeEnFf <= 11'h000;
      end else if (inLoad && eeDone && !chipRst) begin
         flagsFf <= eeImage.present ? eeImage.flags : '0;
         wakeEnFf <= eeImage.present ? eeImage.wakeEn : 11'h000;
      end else if (wrWake) begin
         wakeEnFf <= regWrData[10:0];
      end
   end

   // mode flag survives a chip reset until the new decision
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wakeWaitMode <= 1'b0;
      end else if (inLoad && eeDone && !chipRst) begin
         wakeWaitMode <= wakeEntry;
      end
   end

   // pin direction and output registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         dirFf <= `PMEWK_DIR_RST;
         outFf <= `PMEWK_OUT_RST;
      end else if (chipRst) begin
         dirFf <= `PMEWK_DIR_RST;
         outFf <= `PMEWK_OUT_RST;
      end else begin
         if (wrDir) begin
            dirFf <= regWrData[10:0];
         end
         if (wrOut) begin
            outFf <= regWrData[10:0];
         end
      end
   end

   // status and pin readback frozen outside normal mode, but chip reset clears status
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         statusFf <= `PMEWK_STS_RST;
         pinInFf <= 11'h000;
      end else if (chipRst) begin
         statusFf <= `PMEWK_STS_RST;
      end else if (inNormal) begin
         statusFf <= nxt_status;
         pinInFf <= gpioIn;
      end
   end

   // wake latch and pulse stretcher
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wakePendFf <= 1'b0;
         pulseCntFf <= 16'h0000;
      end else begin
         wakePendFf <= nxt_wakePend;
         if (chipRst) begin
            pulseCntFf <= 16'h0000;
         end else if (wakeRise) begin
            pulseCntFf <= pulseLen;
         end else if (pulseCntFf != 16'h0000) begin
            pulseCntFf <= pulseCntFf - 16'h0001;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         gpioOut <= 11'h000;
         gpioOe <= 11'h000;
         regRdData <= 32'h00000000;
      end else begin
         gpioOut <= nxt_gpioOut;
         gpioOe <= nxt_gpioOe;
         regRdData <= regRdEn ? rdMux : 32'h00000000;
      end
   end

   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence resetRelease_s;
      inHold && externalChipResetN;
   endsequence

   sequence loadGoesWake_s;
      inLoad && eeDone && externalChipResetN && wakeEntry;
   endsequence

   strap_hiz_a: assert property (
      chipRst |=> strapOe == '0)
      else $error("strap driven during chip reset");

   strap_latch_a: assert property (
      resetRelease_s |=> strapLatFf == $past(strapIn) ##1 eeLoadReq == 0)
      else $error("strap not captured at release");

   self_power_a: assert property (
      inWake |-> flagsFf.selfPowered)
      else $error("wake mode without self power");

   mode_sample_a: assert property (
      (inHold && chipRst) |=> modeSelFf == $past(modeSelLive))
      else $error("mode select not sampled");

   wake_enable_a: assert property (
      inWake |-> flagsFf.enable)
      else $error("wake mode without enable flag");

   wake_entry_a: assert property (
      loadGoesWake_s |=> inWake && wakeWaitMode)
      else $error("wake mode not entered");

   magic_wake_a: assert property (
      (inWake && externalChipResetN && magicPacketDet &&
       !flagsFf.wolLinkSel) |=> wakePendFf)
      else $error("magic packet lost");

   link_wake_a: assert property (
      (inWake && externalChipResetN && linkPartnerDet) |=> wakePendFf)
      else $error("link detect lost");

   wake_hold_a: assert property (
      (wakePendFf && externalChipResetN) |=> wakePendFf)
      else $error("wake cleared without reset");

   reload_req_a: assert property (
      resetRelease_s |=> eeLoadReq ##1 !eeLoadReq)
      else $error("eeprom reload not requested");

   sw_lock_a: assert property (
      (inWake && externalChipResetN) |=> $stable(wakeEnFf) && $stable(dirFf))
      else $error("wake registers changed in wake mode");

   sts_frozen_a: assert property (
      (inWake && externalChipResetN) |=> $stable(statusFf) && $stable(pinInFf))
      else $error("status updated in wake mode");

   wake_pin_a: assert property (
      (wakeRoles && flagsFf.pushPull && !chipRst) |=>
         (gpioOe & $past(resOut)) == $past(resOut))
      else $error("wake pin not driven");

endmodule : pmewk_core

// *** tb/pmewk_ec_model.sv ***
// embedded controller: sets mode select, then pulses the chip reset
module pmewk_ec_model (
   // clock
   input wire logic clk,
   // bench commands
   input wire logic clearReq,
   input wire logic keepWake,
   input wire logic [3:0] lowCyc,
   // pins toward the device
   output logic chipResetN,
   output logic modeSel
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [3:0] seqFf = 4'h0;
   logic lowFf = 1'b0;
   logic selFf = 1'b0;
   logic inLow;

   assign inLow = seqFf != 4'h0 && seqFf <= lowCyc;
   assign chipResetN = !lowFf;
   assign modeSel = selFf;

   // mode select settles one cycle before reset goes low
   // sequencer idles again right after release, ready for the next clear
   always @(posedge clk) begin
      if (clearReq && seqFf == 4'h0) begin
         selFf <= keepWake;
         seqFf <= 4'h1;
      end else if (seqFf > lowCyc) begin
         seqFf <= 4'h0;
      end else if (seqFf != 4'h0) begin
         seqFf <= seqFf + 4'h1;
      end
      lowFf <= inLow;
   end
endmodule : pmewk_ec_model

// *** tb/testbench.sv ***
`include "pmewk_regs.svh"

module testbench;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWrData = 32'h0;
   logic regWrEn = 1'b0;
   logic regRdEn = 1'b0;
   logic [31:0] regRdData;
   logic [31:0] rdv;
   logic [10:0] pins = 11'h7ff;
   logic [10:0] gpioIn;
   logic [10:0] gpioOut;
   logic [10:0] gpioOe;
   logic [1:0] strapIn = 2'b10;
   logic [1:0] strapOut;
   logic [1:0] strapOe;
   logic eeLoadReq;
   logic eeDone = 1'b0;
   logic magic = 1'b0;
   logic link = 1'b0;
   logic wakeMode;
   logic chipResetN;
   logic modeSel;
   logic clearReq = 1'b0;
   logic keepWake = 1'b0;
   logic [3:0] lowCyc = 4'h2;
   logic [2:0] eeCnt = 3'h0;
   logic [31:0] seed = 32'h12798a1d;
   pmewk_pkg::pmewk_ee_s img = '0;
   int loads = 0;
   int errTotal = 0;
   int comparisons = 0;
   int odCnt = 0;
   int odBase = 0;
   localparam logic [15:0] PULSE_S = 16'h0003;
   localparam logic [15:0] PULSE_L = 16'h0006;

   always #50 clk = ~clk;

   // mode select pin sits at 1 or 9 by phy mode
   assign gpioIn = strapIn[0] ? {pins[10], modeSel, pins[8:0]} :
      {pins[10:2], modeSel, pins[0]};

   // eeprom loader answers four cycles after a request
   always @(posedge clk) begin
      eeDone <= eeCnt == 3'h1;
      if (eeLoadReq) begin
         eeCnt <= 3'h3;
         loads <= loads + 1;
      end else if (eeCnt != 3'h0) begin
         eeCnt <= eeCnt - 3'h1;
      end
   end

   // cycles the external wake pin is driven, for pulse length checks
   always @(posedge clk) begin
      if (gpioOe[8]) begin
         odCnt <= odCnt + 1;
      end
   end

   pmewk_core #(.PULSE_SHORT_CYC(PULSE_S), .PULSE_LONG_CYC(PULSE_L)) dut_u (
      .clk(clk), .resetn(resetn), .externalChipResetN(chipResetN),
      .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regRdData(regRdData), .gpioIn(gpioIn),
      .gpioOut(gpioOut), .gpioOe(gpioOe), .strapIn(strapIn),
      .strapFunc(2'b01), .strapOut(strapOut), .strapOe(strapOe),
      .eeLoadReq(eeLoadReq), .eeDone(eeDone), .eeImage(img),
      .magicPacketDet(magic), .linkPartnerDet(link), .wakeWaitMode(wakeMode)
   );

   pmewk_ec_model ec_u (
      .clk(clk), .clearReq(clearReq), .keepWake(keepWake),
      .lowCyc(lowCyc), .chipResetN(chipResetN), .modeSel(modeSel)
   );

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction : xs

   // wake mode needs select, enable and self powered
   function automatic logic expMode(input logic [7:0] fl, input logic k);
      return k & fl[0] & fl[7];
   endfunction : expMode

   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, errTotal);
      if (errTotal == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : results

   task automatic chk(input string nm, input logic [31:0] seen,
         input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errTotal++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWrEn <= 1'b1;
      @(posedge clk);
      regWrEn <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regRdEn <= 1'b1;
      @(posedge clk);
      regRdEn <= 1'b0;
      #1 d = regRdData;
   endtask : rd

   task automatic waitLoad;
      int n;
      n = 0;
      while (eeDone !== 1'b1 && n < 40) begin
         @(posedge clk);
         #1 n++;
      end
      chk("loaderDone", n < 40, 1);
      repeat (2) @(posedge clk);
      #1;
   endtask : waitLoad

   task automatic por;
      resetn <= 1'b0;
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      #1 chk("strapOePor", strapOe, 0);
      waitLoad;
   endtask : por

   task automatic enter(input logic [7:0] fl, input logic [10:0] en,
         input logic k);
      int n;
      int ld;
      ld = loads;
      img.present = 1'b1;
      img.flags = fl;
      img.wakeEn = en;
      seed = xs(seed);
      lowCyc <= 4'h1 + {1'b0, seed[2:0]};
      keepWake <= k;
      clearReq <= 1'b1;
      @(posedge clk);
      clearReq <= 1'b0;
      n = 0;
      while (chipResetN !== 1'b0 && n < 20) begin
         @(posedge clk);
         #1 n++;
      end
      @(posedge clk);
      #1 chk("strapOeRst", strapOe, 0);
      waitLoad;
      chk("reloads", loads, ld + 1);
      chk("wakeMode", wakeMode, expMode(fl, k));
   endtask : enter

   task automatic fire(input int s);
      case (s)
         0: magic <= 1'b1;
         1: link <= 1'b1;
         2: pins[5] <= 1'b0;
         default: pins[10] <= 1'b0;
      endcase
      repeat (2) @(posedge clk);
      magic <= 1'b0;
      link <= 1'b0;
      pins <= 11'h7ff;
      repeat (4) @(posedge clk);
      #1;
   endtask : fire

   initial begin
      #1000000;
      errTotal++;
      results;
   end

   initial begin
      strapIn[1] = seed[4];
      img = '{1'b1, 8'h98, seed[10:0]};
      por;
      rd(`PMEWK_REG_WAKE_EN, rdv);
      chk("wakeEnDefault", rdv[10:0], img.wakeEn);
      rd(`PMEWK_REG_PIN_DIR, rdv);
      chk("dirDefault", rdv[10:0], 0);
      rd(`PMEWK_REG_CFG_STS, rdv);
      chk("strapLatch", rdv[1:0], strapIn);
      chk("strapDrive", {strapOe, strapOut}, 4'b1101);
      for (int i = 0; i < 4; i++) begin
         seed = xs(seed);
         wr(`PMEWK_REG_PIN_DIR, {21'h0, seed[10:0]});
         rd(`PMEWK_REG_PIN_DIR, rdv);
         chk("dirNormal", rdv[10:0], seed[10:0]);
      end
      rd(8'h40, rdv);
      chk("unmapped", rdv, 0);
      for (int i = 0; i < 3; i++) begin
         enter(i == 0 ? 8'h98 : i == 1 ? 8'h19 : 8'h99, 11'h420, 1'b1);
      end
      for (int s = 0; s < 4; s++) begin
         enter(8'h99, 11'h420, 1'b1);
         wr(`PMEWK_REG_PIN_DIR, 32'h7ff);
         chk("wakeIdle", gpioOut[0], 0);
         chk("dirLocked", gpioOe[10:2], 0);
         fire(s);
         chk("wakeOut", gpioOut[0], 1);
         chk("wakeOe", gpioOe[0], 1);
         repeat (20) @(posedge clk);
         #1 chk("wakeHold", gpioOut[0], 1);
      end
      enter(8'h99, 11'h400, 1'b1);
      fire(2);
      chk("pinNotArmed", gpioOut[0], 0);
      img.flags = 8'h99;
      por;
      chk("porEntry", wakeMode, 1);
      strapIn <= 2'b11;
      enter(8'h99, 11'h420, 1'b1);
      fire(2);
      chk("extPin5", gpioOut[8], 0);
      fire(3);
      chk("extWake", gpioOut[8], 1);
      chk("extPin0", gpioOut[0], 0);
      enter(8'h99, 11'h420, 1'b0);
      chk("wakeCleared", gpioOut[8], 0);
      // open drain, active low, pulse, link source, pin 10 active high
      enter(8'he7, 11'h000, 1'b1);
      chk("odIdle", {gpioOe[8], gpioOut[8]}, 2'b01);
      fire(0);
      chk("magicOff", gpioOe[8], 0);
      odBase = odCnt;
      fire(1);
      repeat (8) @(posedge clk);
      #1 chk("pulseLong", odCnt - odBase, PULSE_L);
      odBase = odCnt;
      enter(8'he3, 11'h400, 1'b1);
      repeat (6) @(posedge clk);
      #1 chk("pulseShort", odCnt - odBase, PULSE_S);
      results;
   end
endmodule : testbench
